/* fhi_pkg.sv */
// Shared constants and types for the floppy host I/O interface
package fhi_pkg;

    // Data path width and select code layout
    localparam int         WORD_W         = 12;
    localparam int         ADDR_W         = 9;
    localparam logic [2:0] DEV_FIXED      = 3'h7;
    localparam logic [2:0] DEV_SW_DEFAULT = 3'h0;

    // Operation digit of an io_transfer_instruction
    localparam logic [2:0] OP_NOP       = 3'h0;
    localparam logic [2:0] OP_LOAD_CMD  = 3'h1;
    localparam logic [2:0] OP_XFER      = 3'h2;
    localparam logic [2:0] OP_SKIP_TR   = 3'h3;
    localparam logic [2:0] OP_SKIP_ERR  = 3'h4;
    localparam logic [2:0] OP_SKIP_DONE = 3'h5;
    localparam logic [2:0] OP_INTERRUPT_ENABLE_INSTRUCTION      = 3'h6;
    localparam logic [2:0] OP_INIT      = 3'h7;

    // Vector index of a host_accumulator bit (bit 0 is the MSB there)
    localparam int CMD_FUNC_LSB = 1;
    localparam int CMD_DRIVE    = 4;
    localparam int CMD_MODE8    = 6;
    localparam int CMD_DEN      = 8;
    localparam int CMD_BIT2     = 9;
    localparam int INTERRUPT_ENABLE_INSTRUCTION_EN      = 0;

    // Status word positions for a read strobe
    localparam int STAT_TR    = 0;
    localparam int STAT_DONE  = 1;
    localparam int STAT_ERR   = 2;
    localparam int STAT_IE    = 3;
    localparam int STAT_MODE8 = 4;
    localparam int STAT_BUSY  = 5;

    // Transfer request spacing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TR_GAP12_NS   = 23000000;
    localparam int TR_GAP8_NS    = 18000000;
    localparam int TR_GAP12_CYC  = (TR_GAP12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TR_GAP8_CYC   = (TR_GAP8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W         = 20;

    // Sector size in 12-bit words at single density
    localparam logic [8:0] SECT_WORDS12 = 9'h040;

    typedef enum logic [2:0] {
        FN_FILL    = 3'h0, FN_EMPTY  = 3'h1, FN_WRITE = 3'h2, FN_READ    = 3'h3,
        FN_DENSITY = 3'h4, FN_STATUS = 3'h5, FN_WRDEL = 3'h6, FN_READ_ERR = 3'h7
    } fhi_func_e;

    typedef enum logic {
        LD_IDLE  = 1'b0,
        LD_BYTE2 = 1'b1
    } fhi_load_e;

    typedef struct packed {
        logic              skip;
        logic [WORD_W-1:0] acc;
    } fhi_rsp_s;

    typedef struct packed {
        fhi_func_e func;
        logic      drive;
        logic      mode8;
        logic      density;
        logic      bit2;
    } fhi_cmd_s;

endpackage : fhi_pkg

/* fhi_host_port.sv */
// Host I/O port of the floppy controller: instruction decode, flags, interface register
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
module fhi_host_port #(
    parameter logic [2:0] DEV_SW     = fhi_pkg::DEV_SW_DEFAULT,
    parameter bit         DD_VARIANT = 1'b1,
    parameter int         TR_GAP12   = fhi_pkg::TR_GAP12_CYC,
    parameter int         TR_GAP8    = fhi_pkg::TR_GAP8_CYC
) (
    // Clock and bus reset
    input  wire logic                          clk,
    input  wire logic                          reset,
    // Host instruction port
    input  wire logic [fhi_pkg::ADDR_W-1:0]    io_addr,
    input  wire logic [fhi_pkg::WORD_W-1:0]    io_wdata,
    input  wire logic                          io_wr,
    input  wire logic                          io_rd,
    output fhi_pkg::fhi_rsp_s                  io_rdata,
    output logic                               irq,
    // Controller side
    input  wire logic                          ctl_dir_to_host,
    input  wire logic                          ctl_wr,
    input  wire logic [fhi_pkg::WORD_W-1:0]    ctl_wr_data,
    input  wire logic                          ctl_tr_req,
    input  wire logic                          ctl_done_set,
    input  wire logic                          ctl_err_set,
    output logic                               ctl_run,
    output fhi_pkg::fhi_cmd_s                  ctl_cmd,
    output logic                               ctl_ack,
    output logic                               ctl_init,
    output logic                               ctl_pad,
    output logic [fhi_pkg::WORD_W-1:0]         ctl_ireg
);

    // Counter must hold both gaps
    if (TR_GAP12 < 1 || TR_GAP8 < 1 || TR_GAP12 >= (1 << fhi_pkg::GAP_W) ||
        TR_GAP8 >= (1 << fhi_pkg::GAP_W)) begin : g_bad_gap
        $error("transfer request gap out of range");
    end

    fhi_pkg::fhi_rsp_s           rsp_q;
    fhi_pkg::fhi_cmd_s           cmd_q;
    fhi_pkg::fhi_load_e          ld_q;
    logic [fhi_pkg::WORD_W-1:0]  ireg_q;
    logic [fhi_pkg::GAP_W-1:0]   gap_q;
    logic [8:0]                  words_q;
    logic                        tr_q, err_q, done_q, ie_q, mode8_q, busy_q, pend_q;
    logic                        irq_q, run_q, ack_q, init_q, pad_q;
    logic                        do_init, start_load, two_byte, byte2, xdr_hs, to_host;
    logic                        tr_fire, words_last;
    logic [fhi_pkg::WORD_W-1:0]  status_word;

    // Select code match and operation digit
    function automatic logic hit(input logic [fhi_pkg::ADDR_W-1:0] a, input logic s,
                                 input logic [2:0] op);
        hit = s && a[8:6] == fhi_pkg::DEV_FIXED && a[5:3] == DEV_SW && a[2:0] == op;
    endfunction : hit

    // Word-mode merge of a word going into the accumulator
    function automatic logic [11:0] to_acc(input logic [11:0] acc, input logic [11:0] w,
                                           input logic m8);
        to_acc = m8 ? {acc[11:8], acc[7:0] | w[7:0]} : w;
    endfunction : to_acc

    // Decoded strobes shared by the processes below
    assign do_init    = hit(io_addr, io_wr, fhi_pkg::OP_INIT);
    assign two_byte   = DD_VARIANT && io_wdata[fhi_pkg::CMD_MODE8];
    assign start_load = hit(io_addr, io_wr, fhi_pkg::OP_LOAD_CMD) && !busy_q;
    assign byte2      = hit(io_addr, io_wr, fhi_pkg::OP_XFER) && ld_q == fhi_pkg::LD_BYTE2;
    assign xdr_hs     = hit(io_addr, io_wr, fhi_pkg::OP_XFER) && ld_q == fhi_pkg::LD_IDLE
                        && !done_q;
    assign to_host    = done_q || ctl_dir_to_host;
    assign tr_fire    = pend_q && gap_q == '0;
    assign words_last = words_q + 9'h001 == (fhi_pkg::SECT_WORDS12 << cmd_q.density);

    // Status snapshot for the read strobe
    always_comb begin
        status_word                        = '0;
        status_word[fhi_pkg::STAT_TR]    = tr_q;
        status_word[fhi_pkg::STAT_DONE]  = done_q;
        status_word[fhi_pkg::STAT_ERR]   = err_q;
        status_word[fhi_pkg::STAT_IE]    = ie_q;
        status_word[fhi_pkg::STAT_MODE8] = mode8_q;
        status_word[fhi_pkg::STAT_BUSY]  = busy_q;
    end

    // Answer to the host, valid only in the cycle after a strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= '0;
            if (io_rd) begin
                rsp_q.acc <= status_word;
            end else if (hit(io_addr, io_wr, fhi_pkg::OP_LOAD_CMD)) begin
                rsp_q.acc <= '0;
            end else if (hit(io_addr, io_wr, fhi_pkg::OP_XFER)) begin
                if (ld_q == fhi_pkg::LD_IDLE && to_host)
                    rsp_q.acc <= to_acc(io_wdata, ireg_q, mode8_q);
                else
                    rsp_q.acc <= io_wdata;
            end else if (hit(io_addr, io_wr, fhi_pkg::OP_SKIP_TR)) begin
                rsp_q <= '{skip: tr_q, acc: io_wdata};
            end else if (hit(io_addr, io_wr, fhi_pkg::OP_SKIP_ERR)) begin
                rsp_q <= '{skip: err_q, acc: io_wdata};
            end else if (hit(io_addr, io_wr, fhi_pkg::OP_SKIP_DONE)) begin
                rsp_q <= '{skip: done_q, acc: io_wdata};
            end else if (io_wr && io_addr[8:3] == {fhi_pkg::DEV_FIXED, DEV_SW}) begin
                rsp_q.acc <= io_wdata;
            end
        end
    end

    // The one interface register; its meaning follows the running function
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            ireg_q <= '0;
        end else if (hit(io_addr, io_wr, fhi_pkg::OP_LOAD_CMD)) begin
            ireg_q <= io_wdata;
        end else if (byte2) begin
            ireg_q <= {2'h0, io_wdata[0], io_wdata[1], ireg_q[7:0]};
        end else if (hit(io_addr, io_wr, fhi_pkg::OP_XFER) && !to_host) begin
            ireg_q <= io_wdata;
        end else if (ctl_wr) begin
            ireg_q <= ctl_wr_data;
        end
    end

    // Two-byte command load sequencing
    always_ff @(posedge clk) begin
        if (reset || do_init)
            ld_q <= fhi_pkg::LD_IDLE;
        else if (start_load && two_byte)
            ld_q <= fhi_pkg::LD_BYTE2;
        else if (byte2)
            ld_q <= fhi_pkg::LD_IDLE;
    end

    // Command word handed to the controller and its start pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_q <= '0;
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b0;
            if (do_init) begin
                cmd_q <= '0;
            end else if (start_load) begin
                // Accumulator bit 8 is the top bit of the code and sits at the highest index
                cmd_q.func    <= fhi_pkg::fhi_func_e'({io_wdata[fhi_pkg::CMD_FUNC_LSB+2],
                                  io_wdata[fhi_pkg::CMD_FUNC_LSB+1],
                                  io_wdata[fhi_pkg::CMD_FUNC_LSB]});
                cmd_q.drive   <= io_wdata[fhi_pkg::CMD_DRIVE];
                cmd_q.mode8   <= io_wdata[fhi_pkg::CMD_MODE8];
                cmd_q.density <= two_byte ? 1'b0 : io_wdata[fhi_pkg::CMD_DEN];
                cmd_q.bit2    <= two_byte ? 1'b0 : io_wdata[fhi_pkg::CMD_BIT2];
                run_q         <= !two_byte;
            end else if (byte2) begin
                cmd_q.density <= io_wdata[1];
                cmd_q.bit2    <= io_wdata[0];
                run_q         <= 1'b1;
            end
        end
    end

    // Word mode and busy tracking
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            mode8_q <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            if (start_load)
                mode8_q <= io_wdata[fhi_pkg::CMD_MODE8];
            if (start_load && !two_byte || byte2)
                busy_q <= 1'b1;
            else if (ctl_done_set || ctl_err_set)
                busy_q <= 1'b0;
        end
    end

    // Sticky flags; a set in the same cycle as the clearing skip wins
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            tr_q   <= 1'b0;
            err_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            tr_q   <= (tr_q && !hit(io_addr, io_wr, fhi_pkg::OP_SKIP_TR))
                      || tr_fire || (start_load && two_byte);
            err_q  <= (err_q && !hit(io_addr, io_wr, fhi_pkg::OP_SKIP_ERR))
                      || ctl_err_set;
            done_q <= (done_q && !hit(io_addr, io_wr, fhi_pkg::OP_SKIP_DONE) && !run_q)
                      || ctl_done_set || ctl_err_set || byte2;
        end
    end

    // Interrupt enable and the registered interrupt request
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            ie_q  <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (hit(io_addr, io_wr, fhi_pkg::OP_INTERRUPT_ENABLE_INSTRUCTION))
                ie_q <= io_wdata[fhi_pkg::INTERRUPT_ENABLE_INSTRUCTION_EN];
            irq_q <= done_q && ie_q;
        end
    end

    // Request spacing: a pending request waits out the gap, never dropped
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            gap_q  <= '0;
            pend_q <= 1'b0;
        end else begin
            if (xdr_hs)
                gap_q <= mode8_q ? fhi_pkg::GAP_W'(TR_GAP8) : fhi_pkg::GAP_W'(TR_GAP12);
            else if (gap_q != '0)
                gap_q <= gap_q - 1'b1;
            pend_q <= (pend_q && !tr_fire) || ctl_tr_req;
        end
    end

    // Sector fill count; 12-bit fills end with a pad request for the tail
    always_ff @(posedge clk) begin
        if (reset || do_init) begin
            words_q <= '0;
            pad_q   <= 1'b0;
        end else begin
            pad_q <= 1'b0;
            if (run_q) begin
                words_q <= '0;
            end else if (xdr_hs && !to_host && cmd_q.func == fhi_pkg::FN_FILL && !mode8_q) begin
                words_q <= words_last ? 9'h000 : words_q + 9'h001;
                pad_q   <= words_last;
            end
        end
    end

    // Handshake and initialize pulses toward the controller
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q  <= 1'b0;
            init_q <= 1'b1;
        end else begin
            ack_q  <= xdr_hs;
            init_q <= do_init;
        end
    end

    assign io_rdata = rsp_q;
    assign irq      = irq_q;
    assign ctl_run  = run_q;
    assign ctl_cmd  = cmd_q;
    assign ctl_ack  = ack_q;
    assign ctl_init = init_q;
    assign ctl_pad  = pad_q;
    assign ctl_ireg = ireg_q;

    // All checks run on the one clock and rest while bus reset is high
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_load_clears_acc: assert property (hit(io_addr, io_wr, fhi_pkg::OP_LOAD_CMD) && !io_rd
        |=> io_rdata.acc == '0 && ireg_q == $past(io_wdata))
        else $error("load command did not clear accumulator");
    a_busy_no_run: assert property (hit(io_addr, io_wr, fhi_pkg::OP_LOAD_CMD) && busy_q
        |=> !ctl_run)
        else $error("command started while busy");
    a_byte2_done: assert property (byte2 |=> done_q && ctl_run && ireg_q[11:10] == 2'h0)
        else $error("second command byte did not finish load");
    a_xdr_handshake: assert property (xdr_hs |=> ctl_ack ##1 (!ctl_ack || $past(xdr_hs)))
        else $error("transfer handshake missing");
    a_or_high_nibble: assert property (hit(io_addr, io_wr, fhi_pkg::OP_XFER) && to_host
        && mode8_q && ld_q == fhi_pkg::LD_IDLE && !io_rd
        |=> io_rdata.acc[11:8] == $past(io_wdata[11:8]))
        else $error("8-bit transfer disturbed accumulator bits 0-3");
    a_skip_tr_clear: assert property (hit(io_addr, io_wr, fhi_pkg::OP_SKIP_TR) && tr_q
        && !tr_fire && !io_rd |=> io_rdata.skip && !tr_q)
        else $error("transfer request skip wrong");
    a_err_sets_done: assert property (ctl_err_set && !do_init |=> done_q && err_q)
        else $error("error did not set done");
    a_irq_follow: assert property (done_q && ie_q && !do_init |=> irq)
        else $error("interrupt not raised");
    a_interrupt_enable_instruction_bit: assert property (hit(io_addr, io_wr, fhi_pkg::OP_INTERRUPT_ENABLE_INSTRUCTION)
        |=> ie_q == $past(io_wdata[0]))
        else $error("interrupt enable wrong");
    a_init_mode12: assert property (do_init |=> !mode8_q && ireg_q == '0 && ctl_init
        && !tr_q && !done_q)
        else $error("initialize incomplete");
    a_gap_hold: assert property (pend_q && gap_q > 1 |=> !tr_fire)
        else $error("request raised inside gap");

    // Idle digit, stores into the register, done skip, command start, first command byte and pending request set
    // Only the done skip check is guarded against a controller event in the same cycle, which wins by design
    a_nop_quiet: assert property (hit(io_addr, io_wr, fhi_pkg::OP_NOP) && !io_rd
        |=> io_rdata.acc == $past(io_wdata) && !io_rdata.skip)
        else $error("no-operation changed the accumulator");
    a_xfer_to_reg: assert property (hit(io_addr, io_wr, fhi_pkg::OP_XFER) && !to_host
        && ld_q == fhi_pkg::LD_IDLE && !io_rd
        |=> ctl_ireg == $past(io_wdata) && io_rdata.acc == $past(io_wdata))
        else $error("transfer from accumulator not stored or not returned");
    a_skip_done_clear: assert property (hit(io_addr, io_wr, fhi_pkg::OP_SKIP_DONE) && !io_rd
        && !ctl_done_set && !ctl_err_set
        |=> !done_q && io_rdata.skip == $past(done_q))
        else $error("done skip wrong");
    a_run_decode: assert property (start_load && !two_byte
        |=> ctl_run && ctl_cmd.drive == $past(io_wdata[fhi_pkg::CMD_DRIVE])
        && ctl_cmd.func == $past(io_wdata[fhi_pkg::CMD_FUNC_LSB+2:fhi_pkg::CMD_FUNC_LSB]))
        else $error("command start or decode wrong");
    a_byte1_hold: assert property (start_load && two_byte
        |=> !ctl_run && tr_q && ld_q == fhi_pkg::LD_BYTE2)
        else $error("first command byte started a function");
    a_tr_set_wins: assert property (tr_fire && !do_init |=> tr_q)
        else $error("pending request lost");

endmodule : fhi_host_port

/* fhi_ctl_model.sv */
// Behavioural controller model that sits behind the host port
`timescale 1ns/10ps
module fhi_ctl_model #(
    parameter logic [11:0] PAT = 12'h3C3
) (
    // Clock and bus reset
    input  wire logic              clk,
    input  wire logic              reset,
    // From the host port, except err_inject, which the bench drives
    input  wire logic              ctl_run,
    input  wire fhi_pkg::fhi_cmd_s ctl_cmd,
    input  wire logic              ctl_ack,
    input  wire logic              ctl_init,
    input  wire logic              err_inject,
    input  wire logic              ctl_pad,
    // Back to the host port
    output logic                   ctl_dir_to_host,
    output logic                   ctl_wr,
    output logic [11:0]            ctl_wr_data,
    output logic                   ctl_tr_req,
    output logic                   ctl_done_set,
    output logic                   ctl_err_set
);
    logic [2:0] tr_cnt_q;
    logic [2:0] done_cnt_q;
    logic       init_q;

    // Data qualified by ctl_wr only; inverse otherwise so stale captures show up
    assign ctl_wr_data = ctl_wr ? PAT : ~PAT;

    // Function sequencing: request after start, finish after handshake
    always_ff @(posedge clk) begin
        ctl_wr       <= 1'b0;
        ctl_tr_req   <= 1'b0;
        ctl_done_set <= 1'b0;
        ctl_err_set  <= err_inject;
        init_q       <= ctl_init;
        if (reset) begin
            tr_cnt_q        <= 3'h0;
            done_cnt_q      <= 3'h0;
            ctl_dir_to_host <= 1'b0;
        end else begin
            if (tr_cnt_q != 3'h0) tr_cnt_q <= tr_cnt_q - 3'h1;
            if (tr_cnt_q == 3'h1) ctl_tr_req <= 1'b1;
            if (done_cnt_q != 3'h0) done_cnt_q <= done_cnt_q - 3'h1;
            if (done_cnt_q == 3'h1) ctl_done_set <= 1'b1;
            if (init_q && !ctl_init) done_cnt_q <= 3'h5;
            // A fill keeps asking for words until the port flags the sector tail
            if (ctl_ack && ctl_cmd.func == fhi_pkg::FN_FILL && !ctl_pad)
                tr_cnt_q <= 3'h2;
            else if (ctl_ack)
                done_cnt_q <= 3'h4;
            if (ctl_run) begin
                // Only empty buffer moves data towards the host
                ctl_dir_to_host <= (ctl_cmd.func == fhi_pkg::FN_EMPTY);
                ctl_wr          <= (ctl_cmd.func == fhi_pkg::FN_EMPTY);
                tr_cnt_q        <= 3'h2;
            end
        end
    end
endmodule : fhi_ctl_model

/* fhi_host_port_bench.sv */
// Self-checking testbench for the floppy host I/O port
`timescale 1ns/10ps
module fhi_host_port_bench;
    localparam logic [11:0] PAT = 12'h3C3;
    logic clk, reset, io_wr, io_rd, err_inject;
    logic [8:0] io_addr;
    logic [11:0] io_wdata, ctl_wr_data, ctl_ireg, wd, ex;
    logic ctl_dir_to_host, ctl_wr, ctl_tr_req, ctl_done_set, ctl_err_set;
    logic ctl_run, ctl_ack, ctl_init, ctl_pad, irq, run_s, ack_s, pad_s, last_w;
    fhi_pkg::fhi_rsp_s io_rdata, rsp;
    fhi_pkg::fhi_cmd_s ctl_cmd;
    int n_fail, checks_done;

    fhi_host_port #(.TR_GAP12(4), .TR_GAP8(3)) fhi_host_port_inst (
        .clk(clk), .reset(reset), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .irq(irq), .ctl_dir_to_host(ctl_dir_to_host),
        .ctl_wr(ctl_wr), .ctl_wr_data(ctl_wr_data), .ctl_tr_req(ctl_tr_req),
        .ctl_done_set(ctl_done_set), .ctl_err_set(ctl_err_set), .ctl_run(ctl_run),
        .ctl_cmd(ctl_cmd), .ctl_ack(ctl_ack), .ctl_init(ctl_init), .ctl_pad(ctl_pad),
        .ctl_ireg(ctl_ireg));

    fhi_ctl_model #(.PAT(PAT)) fhi_ctl_model_inst (
        .clk(clk), .reset(reset), .ctl_run(ctl_run), .ctl_cmd(ctl_cmd), .ctl_ack(ctl_ack),
        .ctl_init(ctl_init), .err_inject(err_inject), .ctl_pad(ctl_pad), .ctl_dir_to_host(ctl_dir_to_host),
        .ctl_wr(ctl_wr), .ctl_wr_data(ctl_wr_data), .ctl_tr_req(ctl_tr_req),
        .ctl_done_set(ctl_done_set), .ctl_err_set(ctl_err_set));

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One instruction: strobe for one cycle, answer taken in the following cycle
    task automatic do_op(input logic [2:0] op, input logic [11:0] w, input logic [5:0] sel = 6'h38);
        @(posedge clk);
        io_addr  <= {sel, op};
        io_wdata <= w;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        #1;
        rsp   = io_rdata;
        run_s = ctl_run;
        ack_s = ctl_ack;
        pad_s = ctl_pad;
    endtask : do_op

    task automatic rd_status();
        @(posedge clk);
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        rsp = io_rdata;
    endtask : rd_status

    // Poll a skip instruction until it skips, bounded
    task automatic wait_skip(input logic [2:0] op);
        for (int i = 0; i < 300; i++) begin
            do_op(op, 12'h000);
            if (rsp.skip === 1'b1) break;
        end
        chk("poll skip", {12'h000, rsp.skip}, 13'h0001);
    endtask : wait_skip

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the expected run length
    initial begin
        #(50 * 40000);
        n_fail++;
        end_of_test();
    end

    initial begin
        clk = 1'b0; reset = 1'b1; io_wr = 1'b0; io_rd = 1'b0; err_inject = 1'b0;
        io_addr = 9'h000; io_wdata = 12'h000; n_fail = 0; checks_done = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        wait_skip(fhi_pkg::OP_SKIP_DONE);
        rd_status();
        chk("status after reset", {7'h00, rsp.acc[5:0]}, 13'h0000);
        // Error raises done as well
        @(posedge clk) err_inject <= 1'b1;
        @(posedge clk) err_inject <= 1'b0;
        repeat (3) @(posedge clk);
        for (int s = 1; s < 8; s++) begin
            do_op(fhi_pkg::OP_SKIP_DONE, 12'h000, {3'h7, s[2:0]});
            chk("foreign code", rsp, 13'h0000);
        end
        do_op(fhi_pkg::OP_SKIP_DONE, 12'h000, 6'h30);
        chk("fixed bits", rsp, 13'h0000);
        do_op(fhi_pkg::OP_NOP, 12'h123);
        chk("nop answer", rsp, 13'h0123);
        rd_status();
        chk("status err done", {7'h00, rsp.acc[5:0]}, 13'h0006);
        do_op(fhi_pkg::OP_INTERRUPT_ENABLE_INSTRUCTION, 12'h001);
        repeat (2) @(posedge clk);
        chk("irq on", {12'h000, irq}, 13'h0001);
        do_op(fhi_pkg::OP_INTERRUPT_ENABLE_INSTRUCTION, 12'h000);
        repeat (2) @(posedge clk);
        chk("irq off", {12'h000, irq}, 13'h0000);
        for (int k = 0; k < 4; k++) begin
            do_op((k < 2) ? fhi_pkg::OP_SKIP_ERR : fhi_pkg::OP_SKIP_DONE, 12'h777);
            chk("skip clears", rsp, {~k[0], 12'h777});
        end
        // Every function code, 12-bit mode, drive 1; the fill runs a whole sector
        for (int f = 0; f < 8; f++) begin
            do_op(fhi_pkg::OP_LOAD_CMD, 12'(12'h010 | (f << 1)));
            chk("load acc", {1'b0, rsp.acc}, 13'h0000);
            chk("load run", {12'h000, run_s}, 13'h0001);
            chk("func", {10'h000, ctl_cmd.func}, 13'(f));
            chk("drive", {12'h000, ctl_cmd.drive}, 13'h0001);
            chk("ireg cmd", {1'b0, ctl_ireg}, 13'(12'h010 | (f << 1)));
            if (f == 0) begin
                do_op(fhi_pkg::OP_LOAD_CMD, 12'h00E);
                chk("busy load run", {12'h000, run_s}, 13'h0000);
            end
            wd = 12'h5A5 ^ 12'(f);
            ex = (f == 1) ? PAT : wd;
            for (int w = 0; w < ((f == 0) ? int'(fhi_pkg::SECT_WORDS12) : 1); w++) begin
                wait_skip(fhi_pkg::OP_SKIP_TR);
                do_op(fhi_pkg::OP_XFER, wd);
                last_w = (f == 0) && (w == int'(fhi_pkg::SECT_WORDS12) - 1);
                chk("xfer acc", {1'b0, rsp.acc}, {1'b0, ex});
                chk("xfer ack", {12'h000, ack_s}, 13'h0001);
                chk("sector pad", {12'h000, pad_s}, {12'h000, last_w});
                if (f != 1) chk("xfer ireg", {1'b0, ctl_ireg}, {1'b0, wd});
            end
            wait_skip(fhi_pkg::OP_SKIP_DONE);
        end
        // Two-byte load in 8-bit mode, double density, then OR into low byte
        do_op(fhi_pkg::OP_LOAD_CMD, 12'h042);
        chk("byte1 acc", {1'b0, rsp.acc}, 13'h0000);
        chk("byte1 run", {12'h000, run_s}, 13'h0000);
        wait_skip(fhi_pkg::OP_SKIP_TR);
        do_op(fhi_pkg::OP_XFER, 12'h002);
        chk("byte2 run", {12'h000, run_s}, 13'h0001);
        chk("density", {11'h000, ctl_cmd.density, ctl_cmd.bit2}, 13'h0002);
        chk("byte2 fill", {9'h000, ctl_ireg[11:8]}, 13'h0001);
        chk("mode8", {12'h000, ctl_cmd.mode8}, 13'h0001);
        wait_skip(fhi_pkg::OP_SKIP_TR);
        do_op(fhi_pkg::OP_XFER, 12'hA50);
        chk("byte or", {1'b0, rsp.acc}, 13'h0AD3);
        wait_skip(fhi_pkg::OP_SKIP_DONE);
        // Initialize instruction
        do_op(fhi_pkg::OP_INIT, 12'h000);
        chk("init pulse", {12'h000, ctl_init}, 13'h0001);
        rd_status();
        chk("status init", {8'h00, rsp.acc[4:0]}, 13'h0000);
        chk("ireg init", {1'b0, ctl_ireg}, 13'h0000);
        wait_skip(fhi_pkg::OP_SKIP_DONE);
        end_of_test();
    end
endmodule : fhi_host_port_bench
